// File: core/wtr_top.sv
// watchdog timer with reset cause flags and reset pin disable
// assumes wishbone master on CLK, oscillator and fuse as raw pins
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - power-on reset flag set by power-on, cleared only by writing zero
// - reset pin disable zero keeps external reset, one frees the pin
// - counter advances on rising edges of the 128 kHz oscillator
// - reaching the selected limit gives interrupt or reset per mode
// - restart clears the counter; software restarts before expiry
// - interrupt mode: expiry raises interrupt, no reset, wakes sleep
// - reset mode: expiry issues a system reset
// - combined mode: first expiry interrupts, next one resets
// - always-on fuse forces reset mode, enable one, irq enable zero
// - within four cycles one write sets reset enable and prescaler
// - time-out selectable from about 1 ms to 8 s
// - interrupt flag bit 7 set on expiry in interrupt operation
// - interrupt flag clears when its vector executes
// - writing one clears the interrupt flag, zero leaves it
// - interrupt taken only with global and watchdog enables set
// - control bit layout as given; all reset zero, reset enable open
// - watchdog reset flag forces reset enable to one
// - change enable clears itself four cycles after being set
// - codes 0-9 give 2048..1048576 cycles, 10-13 give 1024..128
// - combined mode vector clears interrupt enable and flag
module wtr_top
  import wtr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic WD_OSC,
  input wire logic ALWAYS_ON_FUSE,
  input wire logic PSW_GIE,
  input wire logic RESTART_REQ,
  input wire logic VEC_ACK,
  output logic IRQ,
  output logic WAKE,
  output logic SYS_RST_REQ,
  output logic EXT_RESET_EN
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  logic fuse_m_q;
  logic fuse_q;
  logic power_on_reset_flag_q;
  logic watchdog_reset_flag_q;
  logic reset_pin_disable_q;
  logic interrupt_flag_bit_q;
  logic interrupt_enable_bit_q;
  logic reset_enable_bit_q;
  logic [3:0] prescaler_field_q;
  wtr_win_type win_q;
  logic [2:0] win_cnt_q;
  logic irq_q;
  logic wake_q;
  logic sys_rst_q;
  logic ext_en_q;
  logic wr_stat;
  logic wr_sys;
  logic wr_wdc;
  logic win_open;
  logic open_req;
  logic apply;
  logic wde_eff;
  logic to_irq;
  logic to_rst;
  wtr_mode_type mode;

  wtr_reg_if r ();
  wtr_cnt_if c ();

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_q);

  // ----------------------------------------------------------------
  // reset release and fuse sampling
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // fuse is a raw pin, two flops before use
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fuse_m_q <= 1'b0;
      fuse_q <= 1'b0;
    end else begin
      fuse_m_q <= ALWAYS_ON_FUSE;
      fuse_q <= fuse_m_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wtr_wb_slave u_bus (
    .clk(CLK),
    .rst_n(rst_n_q),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .adr(WB_ADR_I),
    .sel(WB_SEL_I),
    .dat_i(WB_DAT_I),
    .dat_o(WB_DAT_O),
    .ack(WB_ACK_O),
    .r(r.bus)
  );

  wtr_counter u_cnt (
    .clk(CLK),
    .rst_n(rst_n_q),
    .osc(WD_OSC),
    .c(c.cnt)
  );

  // ----------------------------------------------------------------
  // write strobes and mode
  // ----------------------------------------------------------------
  assign wr_stat = r.wr && r.sel == SEL_STAT;
  assign wr_sys = r.wr && r.sel == SEL_SYS;
  assign wr_wdc = r.wr && r.sel == SEL_WDC;
  assign win_open = win_q == WIN_OPEN;
  assign open_req = wr_wdc && r.wdata[`WTR_CE_BIT]
    && r.wdata[`WTR_RE_BIT] && !win_open;
  assign apply = wr_wdc && win_open && !r.wdata[`WTR_CE_BIT];
  assign wde_eff = reset_enable_bit_q || watchdog_reset_flag_q
    || fuse_q;

  // mode from fuse and enables
  always_comb begin
    if (fuse_q) mode = MODE_RSTM;
    else if (wde_eff && interrupt_enable_bit_q) mode = MODE_BOTH;
    else if (wde_eff) mode = MODE_RSTM;
    else if (interrupt_enable_bit_q) mode = MODE_INTR;
    else mode = MODE_STOP;
  end

  // action taken on expiry
  always_comb begin
    to_irq = 1'b0;
    to_rst = 1'b0;
    unique case (mode)
      MODE_STOP: to_irq = 1'b0;
      MODE_INTR: to_irq = c.timeout;
      MODE_BOTH: begin
        to_irq = c.timeout && !interrupt_flag_bit_q;
        to_rst = c.timeout && interrupt_flag_bit_q;
      end
      MODE_RSTM: to_rst = c.timeout;
    endcase
  end

  // counter control
  assign c.restart = RESTART_REQ || to_rst;
  assign c.run = mode != MODE_STOP;
  assign c.psel = prescaler_field_q;

  // ----------------------------------------------------------------
  // reset cause and system control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) power_on_reset_flag_q <= 1'b1;
    else if (wr_stat && !r.wdata[`WTR_POWER_ON_RESET_FLAG_BIT])
      power_on_reset_flag_q <= 1'b0;
  end

  // watchdog reset cause, set wins over clear
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) watchdog_reset_flag_q <= 1'b0;
    else if (to_rst) watchdog_reset_flag_q <= 1'b1;
    else if (wr_stat && !r.wdata[`WTR_WATCHDOG_RESET_FLAG_BIT])
      watchdog_reset_flag_q <= 1'b0;
  end

  // reset pin disable
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) reset_pin_disable_q <= 1'b0;
    else if (wr_sys) reset_pin_disable_q <= r.wdata[`WTR_RESET_PIN_DISABLE_BIT];
  end

  // ----------------------------------------------------------------
  // change window, self clearing after four cycles
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      win_q <= WIN_SHUT;
      win_cnt_q <= 3'h0;
    end else begin
      unique case (win_q)
        WIN_SHUT: if (open_req) begin
          win_q <= WIN_OPEN;
          win_cnt_q <= `WTR_WIN_LAST;
        end
        WIN_OPEN: begin
          if (apply || win_cnt_q == 3'h0) win_q <= WIN_SHUT;
          win_cnt_q <= win_cnt_q - 3'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // watchdog control fields
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) reset_enable_bit_q <= 1'b0;
    else if (fuse_q) reset_enable_bit_q <= 1'b1;
    else if (wr_wdc && r.wdata[`WTR_RE_BIT]) reset_enable_bit_q <= 1'b1;
    else if (apply && !watchdog_reset_flag_q)
      reset_enable_bit_q <= 1'b0;
  end

  // prescaler only moves inside the window
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) prescaler_field_q <= `WTR_PSEL_RST;
    else if (apply)
      prescaler_field_q <= {r.wdata[`WTR_P3_BIT], r.wdata[2:0]};
  end

  // interrupt enable, dropped by the vector in combined mode
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) interrupt_enable_bit_q <= 1'b0;
    else if (fuse_q) interrupt_enable_bit_q <= 1'b0;
    else if (wr_wdc)
      interrupt_enable_bit_q <= r.wdata[`WTR_IE_BIT];
    else if (VEC_ACK && mode == MODE_BOTH)
      interrupt_enable_bit_q <= 1'b0;
  end

  // interrupt flag, set wins over both clears
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) interrupt_flag_bit_q <= 1'b0;
    else if (to_irq) interrupt_flag_bit_q <= 1'b1;
    else if (VEC_ACK) interrupt_flag_bit_q <= 1'b0;
    else if (wr_wdc && r.wdata[`WTR_IF_BIT])
      interrupt_flag_bit_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // outputs and read back
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      sys_rst_q <= 1'b0;
      ext_en_q <= 1'b1;
    end else begin
      irq_q <= interrupt_flag_bit_q && interrupt_enable_bit_q
        && PSW_GIE;
      wake_q <= interrupt_flag_bit_q && interrupt_enable_bit_q;
      sys_rst_q <= to_rst;
      ext_en_q <= !reset_pin_disable_q;
    end
  end
  assign IRQ = irq_q;
  assign WAKE = wake_q;
  assign SYS_RST_REQ = sys_rst_q;
  assign EXT_RESET_EN = ext_en_q;

  assign r.stat_rd = {4'h0, watchdog_reset_flag_q, 2'h0,
    power_on_reset_flag_q};
  assign r.sys_rd = {4'h0, reset_pin_disable_q, 3'h0};
  assign r.wdc_rd = {interrupt_flag_bit_q, interrupt_enable_bit_q,
    prescaler_field_q[3], win_open, wde_eff, prescaler_field_q[2:0]};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  por_clear_a: assert property (
    $fell(power_on_reset_flag_q) |-> $past(wr_stat)
      && !$past(r.wdata[`WTR_POWER_ON_RESET_FLAG_BIT]))
    else $error("power-on flag cleared without write");
  pin_disable_a: assert property (
    wr_sys |-> ##2 EXT_RESET_EN == !$past(r.wdata[`WTR_RESET_PIN_DISABLE_BIT], 2))
    else $error("reset pin enable wrong");
  reset_pulse_a: assert property (
    SYS_RST_REQ |-> !$past(SYS_RST_REQ) && watchdog_reset_flag_q)
    else $error("reset pulse malformed");
  int_mode_a: assert property (
    c.timeout && mode == MODE_INTR |=> interrupt_flag_bit_q
      ##1 !SYS_RST_REQ)
    else $error("interrupt mode misbehaved");
  combined_a: assert property (
    c.timeout && mode == MODE_BOTH && interrupt_flag_bit_q
      |=> SYS_RST_REQ)
    else $error("second expiry gave no reset");
  fuse_lock_a: assert property (
    fuse_q ##1 fuse_q |-> reset_enable_bit_q && !interrupt_enable_bit_q)
    else $error("fuse lock broken");
  window_end_a: assert property (
    $rose(win_open) |-> ##4 !win_open)
    else $error("change enable stayed past four cycles");
  guarded_chg_a: assert property (
    $changed(prescaler_field_q) || $fell(reset_enable_bit_q)
      |-> $past(win_open))
    else $error("protected field changed outside window");
  watchdog_reset_flag_force_a: assert property (
    watchdog_reset_flag_q && apply |=> reset_enable_bit_q)
    else $error("reset enable not forced");
  flag_clear_a: assert property (
    wr_wdc && r.wdata[`WTR_IF_BIT] && !to_irq |=> !interrupt_flag_bit_q)
    else $error("flag not cleared by one");
  vec_clear_a: assert property (
    VEC_ACK && mode == MODE_BOTH && !wr_wdc && !to_irq
      |=> !interrupt_flag_bit_q && !interrupt_enable_bit_q)
    else $error("vector did not clear enable and flag");
  irq_gate_a: assert property (
    IRQ |-> $past(PSW_GIE) && $past(interrupt_enable_bit_q))
    else $error("interrupt without enables");

  irq_seen_c: cover property (to_irq ##1 interrupt_flag_bit_q);
  rst_seen_c: cover property (to_rst ##1 SYS_RST_REQ);
  apply_seen_c: cover property (open_req ##[1:4] apply);
  restart_seen_c: cover property (RESTART_REQ && c.run);
endmodule : wtr_top

`default_nettype wire

// File: core/wtr_defs.svh
// register offsets, field positions, reset values and counts
// assumes a 50 MHz system clock and a 128 kHz oscillator pin
`ifndef WTR_DEFS_SVH
`define WTR_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define WTR_ADR_STATUS 4'h0
`define WTR_ADR_SYSCTL 4'h4
`define WTR_ADR_WDCSR 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WTR_POWER_ON_RESET_FLAG_BIT 0
`define WTR_WATCHDOG_RESET_FLAG_BIT 3
`define WTR_RESET_PIN_DISABLE_BIT 3
`define WTR_IF_BIT 7
`define WTR_IE_BIT 6
`define WTR_P3_BIT 5
`define WTR_CE_BIT 4
`define WTR_RE_BIT 3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define WTR_PSEL_RST 4'h0
`define WTR_WIN_LAST 3'h3
`define WTR_LONG_CYC 21'h000800
`define WTR_SHORT_CYC 21'h000400
`define WTR_SHORT_CODE 4'hA
`define WTR_RSVD_CODE 4'hE

`endif

// File: core/wtr_pkg.sv
// types and decode helpers shared by the watchdog design
// assumes wtr_defs.svh on the include path
package wtr_pkg;
  `include "wtr_defs.svh"

  // ----------------------------------------------------------------
  // watchdog modes, gray coded along stop-int-both-reset
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOP = 2'h0,
    MODE_INTR = 2'h1,
    MODE_BOTH = 2'h3,
    MODE_RSTM = 2'h2
  } wtr_mode_type;

  // change window state
  typedef enum logic {WIN_SHUT = 1'b0, WIN_OPEN = 1'b1} wtr_win_type;

  // register selected by an address
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_STAT = 2'h1,
    SEL_SYS = 2'h3,
    SEL_WDC = 2'h2
  } wtr_sel_type;

  // address decode, used for reads and writes
  function automatic wtr_sel_type wtr_decode(input logic [3:0] adr);
    wtr_sel_type s;
    s = SEL_NONE;
    if (adr == `WTR_ADR_STATUS) s = SEL_STAT;
    if (adr == `WTR_ADR_SYSCTL) s = SEL_SYS;
    if (adr == `WTR_ADR_WDCSR) s = SEL_WDC;
    return s;
  endfunction : wtr_decode

  // time-out length minus one, in oscillator cycles
  function automatic logic [19:0] wtr_limit(input logic [3:0] code);
    logic [20:0] n;
    n = `WTR_LONG_CYC;
    if (code < `WTR_SHORT_CODE) n = `WTR_LONG_CYC << code;
    else if (code < `WTR_RSVD_CODE)
      n = `WTR_SHORT_CYC >> (code - `WTR_SHORT_CODE);
    n = n - 21'h000001;
    return n[19:0];
  endfunction : wtr_limit
endpackage : wtr_pkg

// File: core/wtr_if.sv
// bundles between the watchdog top and its two helpers
// assumes wtr_pkg compiled first
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// register access from the bus slave
// ----------------------------------------------------------------
interface wtr_reg_if import wtr_pkg::*; ();
  logic wr;
  wtr_sel_type sel;
  logic [7:0] wdata;
  logic [7:0] stat_rd;
  logic [7:0] sys_rd;
  logic [7:0] wdc_rd;
  modport bus(output wr, sel, wdata, input stat_rd, sys_rd, wdc_rd);
  modport regs(input wr, sel, wdata, output stat_rd, sys_rd, wdc_rd);
endinterface : wtr_reg_if

// ----------------------------------------------------------------
// counter control and time-out event
// ----------------------------------------------------------------
interface wtr_cnt_if;
  logic restart;
  logic run;
  logic [3:0] psel;
  logic timeout;
  modport ctl(output restart, run, psel, input timeout);
  modport cnt(input restart, run, psel, output timeout);
endinterface : wtr_cnt_if

`default_nettype wire

// File: core/wtr_wb_slave.sv
// classic wishbone slave for the watchdog byte registers
// assumes one clock, registered ack, data in the low byte lane
`timescale 1ns/10ps
`default_nettype none

module wtr_wb_slave
  import wtr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [3:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack,
  wtr_reg_if.bus r
);
  logic ack_q;
  logic [31:0] dat_q;
  logic take;

  // ----------------------------------------------------------------
  // request decode, write strobe on the acking edge
  // ----------------------------------------------------------------
  assign take = cyc && stb && !ack_q;
  assign r.sel = wtr_decode(adr);
  assign r.wdata = dat_i[7:0];
  assign r.wr = take && we && sel[0];
  assign ack = ack_q;
  assign dat_o = dat_q;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= take;
  end

  // read data, unmapped reads answer zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h00000000;
    end else if (take) begin
      unique case (wtr_decode(adr))
        SEL_STAT: dat_q <= {24'h000000, r.stat_rd};
        SEL_SYS: dat_q <= {24'h000000, r.sys_rd};
        SEL_WDC: dat_q <= {24'h000000, r.wdc_rd};
        SEL_NONE: dat_q <= 32'h00000000;
      endcase
    end
  end

  ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack_q |=> !ack_q) else $error("ack held two cycles");
endmodule : wtr_wb_slave

`default_nettype wire

// File: core/wtr_counter.sv
// watchdog counter advanced by the sampled 128 kHz oscillator
// assumes osc is a free pin, much slower than clk
`timescale 1ns/10ps
`default_nettype none

module wtr_counter
  import wtr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc,
  wtr_cnt_if.cnt c
);
  logic osc_m_q;
  logic osc_s_q;
  logic osc_d_q;
  logic tick;
  logic [19:0] cnt_q;
  logic [19:0] lim;
  logic to_q;

  // ----------------------------------------------------------------
  // oscillator sampling, two flops then edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_m_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_d_q <= 1'b0;
    end else begin
      osc_m_q <= osc;
      osc_s_q <= osc_m_q;
      osc_d_q <= osc_s_q;
    end
  end
  assign tick = osc_s_q && !osc_d_q;
  assign lim = wtr_limit(c.psel);

  // count oscillator cycles, clear on restart or expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 20'h00000;
    else if (c.restart || !c.run) cnt_q <= 20'h00000;
    else if (tick && cnt_q >= lim) cnt_q <= 20'h00000;
    else if (tick) cnt_q <= cnt_q + 20'h00001;
  end

  // one-cycle expiry event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) to_q <= 1'b0;
    else to_q <= c.run && !c.restart && tick && cnt_q >= lim;
  end
  assign c.timeout = to_q;

  restart_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    c.restart |=> cnt_q == 20'h00000 && !c.timeout)
    else $error("restart did not clear counter");
  expiry_at_limit_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    c.timeout |-> $past(cnt_q) >= $past(lim) && cnt_q == 20'h00000)
    else $error("expiry before limit");
endmodule : wtr_counter

`default_nettype wire

// File: dv/wtr_core_model.sv
// core-side model: global enable, restart pulses, vector entry
// assumes one clock shared with the watchdog top
`timescale 1ns/10ps
`default_nettype none

module wtr_core_model (
  input wire logic clk,
  input wire logic gie_en,
  input wire logic kick_en,
  input wire logic irq,
  output logic psw_gie,
  output logic restart_req,
  output logic vec_ack
);
  logic busy_q = 1'b0;
  logic [9:0] kick_q = 10'h000;

  // restart well inside the shortest period used
  always_ff @(posedge clk) begin
    kick_q <= kick_en ? kick_q + 10'h001 : 10'h000;
    restart_req <= kick_en && (kick_q[8:0] == 9'h1FF);
  end

  // vector entered once per raised request
  always_ff @(posedge clk) begin
    psw_gie <= gie_en;
    vec_ack <= irq && !busy_q;
    busy_q <= irq;
  end
endmodule : wtr_core_model

`default_nettype wire

// File: dv/tb_top.sv
// testbench for the watchdog top: bus tasks, scenarios, verdict
// assumes core files and the core model compiled before it
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  `include "wtr_defs.svh"
  logic clk, rst_n, cyc, stb, we, osc, fuse, gie, kick;
  logic irq, wake, srst, ext_en, ack, restart, vec, psw;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat;
  logic [7:0] q;
  int err_total, comparisons, rst_cnt, n;

  wtr_top dut_u (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .WD_OSC(osc), .ALWAYS_ON_FUSE(fuse),
    .PSW_GIE(psw), .RESTART_REQ(restart), .VEC_ACK(vec), .IRQ(irq),
    .WAKE(wake), .SYS_RST_REQ(srst), .EXT_RESET_EN(ext_en));
  wtr_core_model core_u (.clk(clk), .gie_en(gie), .kick_en(kick),
    .irq(irq), .psw_gie(psw), .restart_req(restart), .vec_ack(vec));

  // system clock and a free oscillator at one eighth of it
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #80 osc = ~osc;
  end
  // count reset requests seen
  always @(posedge clk) if (srst === 1'b1) rst_cnt++;

  // ----------------------------------------------------------------
  // compare, bus and wait tasks
  // ----------------------------------------------------------------
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  task chk1(input string nm, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      err_total++;
      $display("Error ack expected 1 seen %b", ack);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk8("register", e, q);
  endtask : rd
  // 0 irq, 1 wake, 2 reset request
  task wait_for(input int w);
    n = 0;
    while (n < 3000 && !(w == 0 ? irq === 1'b1 :
        w == 1 ? wake === 1'b1 : srst === 1'b1)) begin
      @(posedge clk);
      n++;
    end
    chk1("event", 1'b1, n < 3000);
  endtask : wait_for
  task tally_and_finish;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, cyc, stb, we, fuse, gie, kick} = 7'h00;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h00000000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`WTR_ADR_STATUS, 8'h01);
    rd(`WTR_ADR_SYSCTL, 8'h00);
    rd(`WTR_ADR_WDCSR, 8'h00);
    rd(4'hC, 8'h00);
    wr(`WTR_ADR_STATUS, 8'h01);
    rd(`WTR_ADR_STATUS, 8'h01);
    wr(`WTR_ADR_STATUS, 8'h00);
    rd(`WTR_ADR_STATUS, 8'h00);
    chk1("ext reset", 1'b1, ext_en);
    wr(`WTR_ADR_SYSCTL, 8'h08);
    chk1("ext reset", 1'b0, ext_en);
    wr(`WTR_ADR_SYSCTL, 8'h00);
    chk1("ext reset", 1'b1, ext_en);
    // interrupt mode, shortest period, global enable off
    wr(`WTR_ADR_WDCSR, 8'h18);
    wr(`WTR_ADR_WDCSR, 8'h65);
    wait_for(1);
    chk1("period", 1'b1, n >= 1000 && n <= 1050);
    chk1("irq gated", 1'b0, irq);
    rd(`WTR_ADR_WDCSR, 8'hE5);
    wr(`WTR_ADR_WDCSR, 8'hE5);
    rd(`WTR_ADR_WDCSR, 8'h65);
    gie <= 1'b1;
    wait_for(0);
    repeat (6) @(posedge clk);
    rd(`WTR_ADR_WDCSR, 8'h65);
    chk8("resets", 8'h00, 8'(rst_cnt));
    // combined mode: interrupt, then reset
    wr(`WTR_ADR_WDCSR, 8'h6D);
    wait_for(0);
    repeat (6) @(posedge clk);
    rd(`WTR_ADR_WDCSR, 8'h2D);
    wait_for(2);
    kick <= 1'b1;
    repeat (2) @(posedge clk);
    chk8("resets", 8'h01, 8'(rst_cnt));
    rd(`WTR_ADR_STATUS, 8'h08);
    wr(`WTR_ADR_WDCSR, 8'h18);
    wr(`WTR_ADR_WDCSR, 8'h25);
    rd(`WTR_ADR_WDCSR, 8'h2D);
    repeat (3000) @(posedge clk);
    chk8("resets", 8'h01, 8'(rst_cnt));
    wr(`WTR_ADR_STATUS, 8'h00);
    wr(`WTR_ADR_WDCSR, 8'h18);
    wr(`WTR_ADR_WDCSR, 8'h25);
    rd(`WTR_ADR_WDCSR, 8'h25);
    // window closes by itself
    wr(`WTR_ADR_WDCSR, 8'h18);
    rd(`WTR_ADR_WDCSR, 8'h3D);
    repeat (6) @(posedge clk);
    rd(`WTR_ADR_WDCSR, 8'h2D);
    wr(`WTR_ADR_WDCSR, 8'h25);
    rd(`WTR_ADR_WDCSR, 8'h2D);
    wr(`WTR_ADR_WDCSR, 8'h18);
    wr(`WTR_ADR_WDCSR, 8'h25);
    // always-on fuse locks the enables
    fuse <= 1'b1;
    repeat (8) @(posedge clk);
    wr(`WTR_ADR_WDCSR, 8'h40);
    rd(`WTR_ADR_WDCSR, 8'h2D);
    kick <= 1'b0;
    wait_for(2);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
